//--- logic/dsrs_map.svh
// Constants of the dual serial register slave
`ifndef DSRS_MAP_SVH
`define DSRS_MAP_SVH
`define DSRS_I2C_ADDR_HI 6'h3b
`define DSRS_BIT_LAST 3'h7
`define DSRS_SPI_ADDR_MSB 1'h0
`endif

//--- logic/dsrs_pkg.sv
// Types of the dual serial register slave
package dsrs_pkg;
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dsrs_req_type;
endpackage : dsrs_pkg

//--- logic/dsrs_sync.sv
// Two-flop synchroniser with edge detection after the second stage
`timescale 1ns/100ps
module dsrs_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Raw pins
  input wire logic [WIDTH-1:0] async_i,
  // Synchronised levels and edges
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  initial
  begin
    if (WIDTH < 1)
    begin
      $error("WIDTH must be at least 1");
    end
  end
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;
endmodule : dsrs_sync

//--- logic/dsrs_slave.sv
// I2C and SPI register slave with automatic interface selection
`timescale 1ns/100ps
`include "dsrs_map.svh"
// What this block does
// - Chip select high I2C, low SPI
// - Any chip select low locks out I2C
// - Slave for standard, fast, high-speed I2C
// - Never drive or stretch the I2C clock
// - I2C address fixed six bits plus pin
// - I2C write: address and data pairs stored
// - I2C read: auto-increment until master nack
// - SPI mode from clock level after select
// - Three-wire mode shares data pin, output tristate
// - Sample rising edge, shift out falling edge
// - Control byte: direction flag, seven address bits
// - SPI write: control and data pairs stored
// - SPI read: shift data, auto-increment address
// - Shadowed data gives consistent read bursts
module dsrs_slave
  import dsrs_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Serial pins
  input wire logic csb_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  output logic sdi_o,
  output logic sdi_oe_o,
  input wire logic sdo_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Configuration
  input wire logic three_wire_enable_i,
  // Register port
  output dsrs_req_type req_o,
  input wire logic [7:0] rdata_i,
  output logic shadow_hold_o
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_ADDR = 6'h02, ST_RX = 6'h04,
    ST_TX = 6'h08, ST_ACK = 6'h10, ST_SKIP = 6'h20
  } dsrs_state_type;

  logic [2:0] lvl;
  logic [2:0] ris;
  logic [2:0] fal;
  dsrs_sync #(.WIDTH(3)) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({csb_i, sck_i, sdi_i}),
    .level_o(lvl),
    .rise_o(ris),
    .fall_o(fal)
  );
  logic sdo_s1_q;
  logic sdo_s2_q;
  logic cs;
  logic sck;
  logic sda;
  logic sck_r;
  logic sck_f;
  logic sda_r;
  logic sda_f;
  assign cs = lvl[2];
  assign sck = lvl[1];
  assign sda = lvl[0];
  assign sck_r = ris[1];
  assign sck_f = fal[1];
  assign sda_r = ris[0];
  assign sda_f = fal[0];

  logic i2c_off_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic [7:0] addr_q;
  logic rd_q;
  logic have_addr_q;
  logic ack_drv_q;
  logic spi_data_q;
  logic ctl_done_q;
  logic spi_rd_q;
  logic sample_wait_q;
  logic sample_pol_q;
  dsrs_req_type req_q;
  logic [7:0] rx;
  logic i2c_start;
  logic i2c_stop;
  assign rx = {sh_q[6:0], sda};
  assign i2c_start = sda_f && sck && !i2c_off_q && cs;
  assign i2c_stop = sda_r && sck && !i2c_off_q && cs;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sdo_s1_q <= 1'h0;
      sdo_s2_q <= 1'h0;
    end
    else
    begin
      sdo_s1_q <= sdo_i;
      sdo_s2_q <= sdo_s1_q;
    end
  end

  // Lock persists until reset, which stands in for power-on
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      i2c_off_q <= 1'h0;
    end
    else if (!cs)
    begin
      i2c_off_q <= 1'h1;
    end
  end

  // Clock level is sampled a cycle after the falling select edge
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sample_wait_q <= 1'h0;
      sample_pol_q <= 1'h0;
    end
    else
    begin
      sample_wait_q <= fal[2];
      if (sample_wait_q)
      begin
        sample_pol_q <= sck;
      end
    end
  end

  // SPI engine: mode 00 and 11 both sample rising, shift falling
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || cs)
    begin
      cnt_q <= 3'h0;
      ctl_done_q <= 1'h0;
      spi_rd_q <= 1'h0;
      spi_data_q <= 1'h1;
    end
    else
    begin
      if (sck_r)
      begin
        cnt_q <= cnt_q + 3'h1;
        // Read data bytes must not be decoded as new control bytes
        if (cnt_q == `DSRS_BIT_LAST && !ctl_done_q && !spi_rd_q)
        begin
          ctl_done_q <= !rx[7];
          spi_rd_q <= rx[7];
        end
        else if (cnt_q == `DSRS_BIT_LAST)
        begin
          ctl_done_q <= 1'h0;
        end
      end
      if (sck_f && spi_rd_q)
      begin
        spi_data_q <= (cnt_q == 3'h0) ? rdata_i[7] : sh_q[7];
      end
    end
  end

  // Shared shifter, address and request generation
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sh_q <= 8'h00;
      addr_q <= 8'h00;
      req_q <= '0;
    end
    else
    begin
      req_q.we <= 1'h0;
      req_q.re <= 1'h0;
      if (!cs)
      begin
        if (sck_r)
        begin
          // While reading, the shifter only moves on falling edges
          if (!spi_rd_q)
          begin
            sh_q <= rx;
          end
          if (cnt_q == `DSRS_BIT_LAST && !ctl_done_q && !spi_rd_q)
          begin
            addr_q <= {`DSRS_SPI_ADDR_MSB, rx[6:0]};
            if (rx[7])
            begin
              req_q.re <= 1'h1;
              req_q.addr <= {`DSRS_SPI_ADDR_MSB, rx[6:0]};
            end
          end
          else if (cnt_q == `DSRS_BIT_LAST && ctl_done_q)
          begin
            req_q.we <= 1'h1;
            req_q.addr <= addr_q;
            req_q.wdata <= rx;
          end
          else if (cnt_q == `DSRS_BIT_LAST && spi_rd_q)
          begin
            addr_q <= addr_q + 8'h01;
            req_q.re <= 1'h1;
            req_q.addr <= addr_q + 8'h01;
          end
        end
        if (sck_f && spi_rd_q && cnt_q == 3'h0)
        begin
          sh_q <= {rdata_i[6:0], 1'h0};
        end
        else if (sck_f && spi_rd_q)
        begin
          sh_q <= {sh_q[6:0], 1'h0};
        end
      end
    end
  end

  // Address byte matches the fixed bits plus the strap pin
  function automatic logic addr_hit(input logic [7:0] s, input logic strap);
    addr_hit = s[7:1] == {`DSRS_I2C_ADDR_HI, strap};
  endfunction : addr_hit

  // I2C bit engine kept apart from the SPI counter
  logic [3:0] ib_q;
  logic [7:0] ish_q;
  logic i2c_we;
  logic i2c_re;
  logic [7:0] i2c_a;
  logic [7:0] i2c_w;
  dsrs_state_type ist_q;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || i2c_off_q || !cs || i2c_stop)
    begin
      ist_q <= ST_IDLE;
      ib_q <= 4'h0;
      ish_q <= 8'h00;
      i2c_we <= 1'h0;
      i2c_re <= 1'h0;
      i2c_a <= 8'h00;
      i2c_w <= 8'h00;
    end
    else if (i2c_start)
    begin
      ist_q <= ST_ADDR;
      ib_q <= 4'h0;
      i2c_we <= 1'h0;
      i2c_re <= 1'h0;
    end
    else
    begin
      i2c_we <= 1'h0;
      i2c_re <= 1'h0;
      if (sck_r && ist_q != ST_ACK && ist_q != ST_IDLE && ist_q != ST_SKIP)
      begin
        ish_q <= {ish_q[6:0], sda};
        ib_q <= ib_q + 4'h1;
      end
      if (sck_r && ist_q == ST_ACK && rd_q && sda)
      begin
        ist_q <= ST_SKIP;
      end
      if (sck_f && ib_q == 4'h8)
      begin
        ib_q <= 4'h0;
        case (ist_q)
          ST_ADDR:
          begin
            if (addr_hit(ish_q, sdo_s2_q))
            begin
              ist_q <= ST_ACK;
            end
            else
            begin
              ist_q <= ST_SKIP;
            end
          end
          ST_RX:
          begin
            ist_q <= ST_ACK;
            if (have_addr_q)
            begin
              i2c_we <= 1'h1;
              i2c_a <= i2c_a;
              i2c_w <= ish_q;
            end
            else
            begin
              i2c_a <= ish_q;
            end
          end
          ST_TX:
          begin
            ist_q <= ST_ACK;
          end
          default:
          begin
          end
        endcase
      end
      else if (sck_f && ist_q == ST_ACK)
      begin
        ist_q <= rd_q ? ST_TX : ST_RX;
        if (rd_q)
        begin
          i2c_re <= 1'h1;
        end
      end
    end
  end

  // Direction, address flag, pin drive for I2C
  always_ff @(posedge mclk_i)
  begin
    // Pairing restarts with every start or stop condition
    if (rst_i || i2c_off_q || !cs || i2c_start || i2c_stop)
    begin
      rd_q <= 1'h0;
      have_addr_q <= 1'h0;
      ack_drv_q <= 1'h0;
    end
    else if (sck_f && ib_q == 4'h8 && ist_q == ST_ADDR)
    begin
      rd_q <= ish_q[0];
      ack_drv_q <= addr_hit(ish_q, sdo_s2_q);
    end
    else if (sck_f && ib_q == 4'h8 && ist_q == ST_RX)
    begin
      have_addr_q <= !have_addr_q;
      ack_drv_q <= 1'h1;
    end
    else if (sck_f && ist_q == ST_ACK && rd_q)
    begin
      ack_drv_q <= !rdata_i[7];
    end
    else if (sck_f && ist_q == ST_TX)
    begin
      ack_drv_q <= (ib_q != 4'h8) && !rdata_i[3'h7 - ib_q[2:0]];
    end
    else if (sck_f)
    begin
      ack_drv_q <= 1'h0;
    end
  end

  // I2C read address advances after each byte sent
  logic [7:0] i2c_ra_q;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      i2c_ra_q <= 8'h00;
    end
    else if (i2c_we)
    begin
      i2c_ra_q <= i2c_a + 8'h01;
    end
    else if (sck_f && ib_q == 4'h8 && ist_q == ST_RX && !have_addr_q)
    begin
      i2c_ra_q <= ish_q;
    end
    else if (sck_f && ib_q == 4'h8 && ist_q == ST_TX)
    begin
      i2c_ra_q <= i2c_ra_q + 8'h01;
    end
  end

  always_comb
  begin
    req_o = req_q;
    if (i2c_we)
    begin
      req_o.we = 1'h1;
      req_o.addr = i2c_a;
      req_o.wdata = i2c_w;
    end
    else if (cs)
    begin
      req_o.re = i2c_re;
      req_o.addr = i2c_ra_q;
    end
  end

  // Shadow stays frozen for a whole frame so bursts stay coherent
  assign shadow_hold_o = !cs || (ist_q != ST_IDLE);
  // Clock pin has no output at all
  assign sdi_o = three_wire_enable_i && !cs ? spi_data_q : 1'h0;
  assign sdi_oe_o = (!cs && three_wire_enable_i && spi_rd_q) || (cs && ack_drv_q);
  assign sdo_o = spi_data_q;
  assign sdo_oe_o = !cs && !three_wire_enable_i;
endmodule : dsrs_slave

//--- testbench/dsrs_slave_sva.sv
// Assertions on the ports of the register slave
`timescale 1ns/100ps
module dsrs_slave_sva
  import dsrs_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Pins and register port
  input wire logic csb_i,
  input wire logic sck_i,
  input wire logic sdi_o,
  input wire logic sdi_oe_o,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic three_wire_enable_i,
  input wire dsrs_req_type req_o
);
  logic spi_seen_q;
  logic [3:0] hi_cnt_q;
  always_ff @(posedge mclk_i)
    if (rst_i)
      spi_seen_q <= 1'b0;
    else if (!csb_i)
      spi_seen_q <= 1'b1;
  // Saturates so a long I2C stretch never wraps back into the window
  always_ff @(posedge mclk_i)
    if (rst_i || !csb_i)
      hi_cnt_q <= 4'h0;
    else if (hi_cnt_q != 4'hf)
      hi_cnt_q <= hi_cnt_q + 4'h1;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_i2c_sel;
    csb_i [*8];
  endsequence
  sequence s_spi_4w;
    (!csb_i && !three_wire_enable_i) [*8];
  endsequence
  sequence s_spi_write;
    req_o.we && !csb_i;
  endsequence
  a_sdo_idle_off: assert property (s_i2c_sel |-> !sdo_oe_o)
    else $error("sdo driven while deselected");
  a_sdo_spi_on: assert property (s_spi_4w |-> sdo_oe_o)
    else $error("sdo not driven in four-wire select");
  a_sdo_three_off: assert property (three_wire_enable_i [*4] |-> !sdo_oe_o)
    else $error("sdo driven in three-wire mode");
  a_i2c_locked: assert property (spi_seen_q && hi_cnt_q == 4'hf |-> !sdi_oe_o)
    else $error("sda driven after lockout");
  a_i2c_pull_low: assert property (s_i2c_sel ##0 sdi_oe_o |-> !sdi_o)
    else $error("sda driven high in I2C");
  a_we_pulse: assert property (req_o.we |=> !req_o.we)
    else $error("write strobe longer than one cycle");
  a_re_pulse: assert property (req_o.re |=> !req_o.re)
    else $error("read strobe longer than one cycle");
  a_spi_addr_msb: assert property (s_spi_write |-> !req_o.addr[7])
    else $error("spi address msb set");
  a_spi_wr_rise: assert property (s_spi_write |-> sck_i && $past(sck_i, 2))
    else $error("spi write not after rising clock");
  a_sdo_on_fall: assert property (sdo_oe_o && $past(sdo_oe_o) && !csb_i && $changed(sdo_o)
    |-> !sck_i)
    else $error("sdo changed while clock high");
endmodule : dsrs_slave_sva
bind dsrs_slave dsrs_slave_sva sva_i (.mclk_i(mclk_i), .rst_i(rst_i), .csb_i(csb_i),
  .sck_i(sck_i), .sdi_o(sdi_o), .sdi_oe_o(sdi_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
  .three_wire_enable_i(three_wire_enable_i), .req_o(req_o));

//--- testbench/dsrs_master_model.sv
// Serial bus master model for I2C and SPI
`timescale 1ns/100ps
module dsrs_master_model (
  // Clock
  input wire logic mclk_i,
  // Bus pins
  input wire logic sda_i,
  input wire logic sdo_i,
  output logic csb_o,
  output logic sck_o,
  output logic sda_o,
  output logic sda_oe_o
);
  initial
  begin
    csb_o = 1'b1;
    sck_o = 1'b1;
    sda_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Sixteen cycles give a 128 ns link period, held off the sampling edge
  task automatic half(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : half
  task automatic spi_start(input logic cpol);
    sck_o = cpol;
    half(16);
    csb_o = 1'b0;
    half(16);
  endtask : spi_start
  task automatic spi_stop(input logic cpol);
    sck_o = cpol;
    half(16);
    csb_o = 1'b1;
    sda_oe_o = 1'b0;
    half(16);
  endtask : spi_stop
  task automatic spi_byte(input logic [7:0] tx, input logic drv, input logic tw,
    output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck_o = 1'b0;
      sda_oe_o = drv;
      sda_o = tx[i];
      half(16);
      sck_o = 1'b1;
      rx[i] = tw ? sda_i : sdo_i;
      half(16);
    end
  endtask : spi_byte
  task automatic i2c_start;
    sda_oe_o = 1'b0;
    sck_o = 1'b1;
    half(16);
    sda_oe_o = 1'b1;
    sda_o = 1'b0;
    half(16);
    sck_o = 1'b0;
    half(4);
  endtask : i2c_start
  // Open drain: only zeros are driven, ones are left to the pull-up
  task automatic i2c_byte(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      sda_o = w[i];
      sda_oe_o = !w[i];
      half(12);
      sck_o = 1'b1;
      r[i] = sda_i;
      half(16);
      sck_o = 1'b0;
      half(4);
    end
  endtask : i2c_byte
  task automatic i2c_stop;
    sda_o = 1'b0;
    sda_oe_o = 1'b1;
    half(12);
    sck_o = 1'b1;
    half(16);
    sda_oe_o = 1'b0;
    half(16);
  endtask : i2c_stop
endmodule : dsrs_master_model

//--- testbench/tb.sv
// Self-checking bench for the dual serial register slave
`timescale 1ns/100ps
module tb;
  import dsrs_pkg::*;
  logic mclk_i, rst_i, three_wire_enable_i, sdo_strap;
  logic csb, sck, m_sda, m_oe, sda, sdo_w;
  logic sdi_o, sdi_oe_o, sdo_o, sdo_oe_o, shadow_hold_o;
  dsrs_req_type req_o;
  logic [7:0] rdata_i, wa, wd;
  logic [8:0] r;
  int wn, failures, check_count;
  assign sda = sdi_oe_o ? sdi_o : (m_oe ? m_sda : 1'b1);
  assign sdo_w = sdo_oe_o ? sdo_o : sdo_strap;
  // Register contents are a fixed pattern of the address
  assign rdata_i = req_o.addr ^ 8'h3c;
  dsrs_slave uut (.mclk_i(mclk_i), .rst_i(rst_i), .csb_i(csb), .sck_i(sck), .sdi_i(sda),
    .sdi_o(sdi_o), .sdi_oe_o(sdi_oe_o), .sdo_i(sdo_w), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .three_wire_enable_i(three_wire_enable_i), .req_o(req_o), .rdata_i(rdata_i),
    .shadow_hold_o(shadow_hold_o));
  dsrs_master_model m (.mclk_i(mclk_i), .sda_i(sda), .sdo_i(sdo_w), .csb_o(csb),
    .sck_o(sck), .sda_o(m_sda), .sda_oe_o(m_oe));
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
    if (req_o.we === 1'b1)
    begin
      wa <= req_o.addr;
      wd <= req_o.wdata;
      wn <= wn + 1;
    end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic t_i2c_wr(input logic s);
    int n0;
    n0 = wn;
    sdo_strap = s;
    m.i2c_start();
    m.i2c_byte({6'h3b, s, 2'h1}, r);
    chk("addr ack", 8'h00, {7'h00, r[0]});
    m.i2c_byte(9'h021, r);
    m.i2c_byte(9'h0b5, r);
    m.i2c_byte(9'h023, r);
    m.i2c_byte(9'h187, r);
    m.i2c_stop();
    chk("i2c writes", 8'h02, 8'(wn - n0));
    chk("i2c addr", 8'h11, wa);
    chk("i2c data", 8'hc3, wd);
    $display("test i2c write done");
  endtask : t_i2c_wr
  task automatic t_i2c_nak(input logic [7:0] ab);
    int n0;
    n0 = wn;
    sdo_strap = 1'b0;
    three_wire_enable_i = 1'b0;
    m.i2c_start();
    m.i2c_byte({ab, 1'b1}, r);
    chk("addr nak", 8'h01, {7'h00, r[0]});
    m.i2c_byte(9'h021, r);
    m.i2c_byte(9'h0b5, r);
    m.i2c_stop();
    chk("no writes", 8'h00, 8'(wn - n0));
    $display("test i2c refusal done");
  endtask : t_i2c_nak
  task automatic t_i2c_rd;
    sdo_strap = 1'b1;
    m.i2c_start();
    m.i2c_byte(9'h1dd, r);
    m.i2c_byte(9'h041, r);
    m.i2c_start();
    m.i2c_byte(9'h1df, r);
    chk("read ack", 8'h00, {7'h00, r[0]});
    m.i2c_byte(9'h1fe, r);
    chk("i2c rd0", 8'h1c, r[8:1]);
    m.i2c_byte(9'h1ff, r);
    chk("i2c rd1", 8'h1d, r[8:1]);
    m.i2c_stop();
    $display("test i2c read done");
  endtask : t_i2c_rd
  task automatic t_spi_wr;
    int n0;
    logic [7:0] x;
    n0 = wn;
    three_wire_enable_i = 1'b0;
    m.spi_start(1'b1);
    m.spi_byte(8'h22, 1'b1, 1'b0, x);
    m.spi_byte(8'ha5, 1'b1, 1'b0, x);
    chk("spi addr0", 8'h22, wa);
    chk("spi data0", 8'ha5, wd);
    chk("shadow hold", 8'h01, {7'h00, shadow_hold_o});
    m.spi_byte(8'h7f, 1'b1, 1'b0, x);
    m.spi_byte(8'h81, 1'b1, 1'b0, x);
    m.spi_stop(1'b1);
    chk("shadow free", 8'h00, {7'h00, shadow_hold_o});
    chk("spi writes", 8'h02, 8'(wn - n0));
    chk("spi addr1", 8'h7f, wa);
    chk("spi data1", 8'h81, wd);
    $display("test spi write done");
  endtask : t_spi_wr
  task automatic t_spi_rd(input logic tw, input logic cpol);
    logic [7:0] x;
    three_wire_enable_i = tw;
    m.spi_start(cpol);
    m.spi_byte(8'h85, 1'b1, tw, x);
    m.spi_byte(8'h00, !tw, tw, x);
    chk("spi rd0", 8'h39, x);
    m.spi_byte(8'h00, !tw, tw, x);
    chk("spi rd1", 8'h3a, x);
    m.spi_stop(cpol);
    $display("test spi read done");
  endtask : t_spi_rd
  initial
  begin
    rst_i = 1'b1;
    three_wire_enable_i = 1'b0;
    sdo_strap = 1'b0;
    wn = 0;
    failures = 0;
    check_count = 0;
    repeat (12) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    t_i2c_wr(1'b0);
    t_i2c_wr(1'b1);
    t_i2c_nak(8'ha0);
    t_i2c_rd();
    t_spi_wr();
    t_spi_rd(1'b0, 1'b0);
    t_spi_rd(1'b1, 1'b1);
    t_i2c_nak(8'hec);
    rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    t_i2c_wr(1'b0);
    close_out();
  end
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    failures++;
    $display("watchdog expired");
    close_out();
  end
endmodule : tb
